// File: core/dif_defs.svh
// constants for the drive input function logic: register map, function codes, timing
// assumes a 50 MHz control clock and a classic wishbone slave with 32-bit data
`ifndef DIF_DEFS_SVH
`define DIF_DEFS_SVH

`define DIF_CLK_HZ          50000000
`define DIF_JOG_CONFLICT_MS 500
`define DIF_SH_HOLD_MS      100
`define DIF_JOG_CONFLICT_CYC ((`DIF_CLK_HZ / 1000) * `DIF_JOG_CONFLICT_MS)
`define DIF_SH_HOLD_CYC      ((`DIF_CLK_HZ / 1000) * `DIF_SH_HOLD_MS)

`define DIF_REG_CTRL   8'h00
`define DIF_REG_FUNC   8'h04
`define DIF_REG_POL    8'h08
`define DIF_REG_UPLIM  8'h0C
`define DIF_REG_LOLIM  8'h10
`define DIF_REG_JOGREF 8'h14
`define DIF_REG_STEP   8'h18
`define DIF_REG_STATUS 8'h1C
`define DIF_REG_FREF   8'h20
`define DIF_REG_CMD    8'h24

`define DIF_CTRL_HOLD    0
`define DIF_CTRL_REVPRO  1
`define DIF_CTRL_LIMSRC  2
`define DIF_CTRL_PIDEN   4
`define DIF_CTRL_RESET   32'h0000_0000
`define DIF_UPLIM_RESET  16'hFFFF
`define DIF_STEP_RESET   16'h0001

`define DIF_FN_UP      8'h10
`define DIF_FN_DOWN    8'h11
`define DIF_FN_FORWARD_JOG_INPUT    8'h12
`define DIF_FN_REVERSE_JOG_INPUT    8'h13
`define DIF_FN_FRESET  8'h14
`define DIF_FN_FSTOP_NO 8'h15
`define DIF_FN_MOTOR2  8'h16
`define DIF_FN_FSTOP_NC 8'h17
`define DIF_FN_PIDCAN  8'h19
`define DIF_FN_ACC1    8'h07
`define DIF_FN_ACC2    8'h1A
`define DIF_FN_LOCK    8'h1B
`define DIF_FN_SH      8'h1E
`define DIF_FN_RHOLD   8'h0A
`define DIF_FN_OFS0    8'h44
`define DIF_FN_OFS2    8'h46
`define DIF_FN_AUP     8'h75
`define DIF_FN_ADN     8'h76
`define DIF_UNMAPPED   32'h0000_0000

`endif

// File: core/dif_pkg.sv
// types for the drive input function logic
// assumes dif_defs.svh sits beside it
package dif_pkg;
  typedef enum logic [1:0] {
    DIF_RUN_IDLE,
    DIF_RUN_ON,
    DIF_RUN_FSTOP,
    DIF_RUN_FAULT
  } dif_run_t;

  typedef struct packed {
    logic        fwd;
    logic        rev;
    logic        jog;
    logic        coast;
    logic        fast_decel;
    logic        motor2;
    logic        pid_active;
    logic [1:0]  ramp_set;
    logic        lockout;
  } dif_drive_t;
endpackage

// File: core/dif_input_logic.sv
// drive input function logic: terminal decode, up/down reference, jog, fault,
// fast-stop, motor select, pid cancel, ramp select, lockout, sample/hold
// assumes terminal inputs synchronous to clk_i; analog levels already digitised
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`include "dif_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - up raises, down lowers, both or none hold
// - hold off: clear reference on run drop
// - hold on: keep reference across run cycles
// - up or down without run clears reference
// - reference never exceeds upper limit, except the jog reference
// - stored lower limit: accelerate on run
// - analog lower limit: needs run plus up/down
// - both limits: stored first, analog needs up/down
// - jog inputs run without run command
// - jog overrides; reverse jog ignored if prohibited
// - both jogs 500 ms raise external fault
// - fault closes contact, output coasts
// - fault reset ignored while run present
// - fast-stop decelerates with fast-stop time
// - restart needs stop, input off, run off
// - motor 2 input selects second sets, output
// - motor change during run raises alarm
// - pid cancel suspends pid while closed
// - second select with first picks sets
// - lockout open rejects parameter writes
// - sample/hold 100 ms adopts analog reference
// - power-up starts from zero reference
// - sample/hold combined with up/down, reference hold, AUP/ADN or offsets flags conflict
module dif_input_logic
  import dif_pkg::*;
#(
  parameter int NUM_TERM  = 5,
  parameter int JOG_CYC   = `DIF_JOG_CONFLICT_CYC,
  parameter int SH_CYC    = `DIF_SH_HOLD_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  output      logic [31:0]           wb_dat_o,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_we_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output      logic                  wb_ack_o,
  input  wire logic [NUM_TERM-1:0]   term_i,
  input  wire logic                  run_fwd_i,
  input  wire logic                  run_rev_i,
  input  wire logic                  reset_key_i,
  input  wire logic                  motor_stopped_i,
  input  wire logic                  fault_event_i,
  input  wire logic [15:0]           analog_ref_i,
  input  wire logic [15:0]           analog_lim_i,
  input  wire logic [15:0]           out_freq_i,
  output      logic [15:0]           freq_ref_o,
  output      dif_drive_t            drive_o,
  output      logic                  fault_contact_o,
  output      logic                  motor2_out_o,
  output      logic                  run_alarm_o,
  output      logic                  input_conflict_error_o
);

  // refuse sizes the decode and counters cannot serve
  generate
    if (NUM_TERM < 1 || NUM_TERM > 8) begin : g_bad_term
      $error("NUM_TERM out of range");
    end
    if (JOG_CYC < 1 || SH_CYC < 1) begin : g_bad_cyc
      $error("timing counts must be positive");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [63:0] func_r, func_nxt;
  logic [7:0]  pol_r, pol_nxt;
  logic [15:0] uplim_r, uplim_nxt, lolim_r, lolim_nxt;
  logic [15:0] jogref_r, jogref_nxt, step_r, step_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [15:0] ud_ref_r, ud_ref_nxt;
  logic [15:0] sh_ref_r, sh_ref_nxt;
  logic        sh_valid_r, sh_valid_nxt, sh_done_r, sh_done_nxt;
  logic [31:0] jog_cnt_r, jog_cnt_nxt, sh_cnt_r, sh_cnt_nxt;
  logic        motor2_r, motor2_nxt, alarm_r, alarm_nxt;
  logic        fault_r, fault_nxt, stored_reached_r, stored_reached_nxt;
  logic        rejected_r, rejected_nxt;
  dif_run_t    st_r, st_nxt;
  logic [15:0] fref_r, fref_nxt;
  dif_drive_t  drv_r, drv_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // terminal decode
  logic [NUM_TERM-1:0] act;
  logic f_up, f_dn, f_forward_jog_input, f_reverse_jog_input, f_frst, f_fstop, f_m2, f_pidc, f_acc1, f_acc2;
  logic f_lock, f_sh, has_lock, has_sh, has_up, has_dn, conflict;
  logic [7:0] fn [NUM_TERM];

  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_term
      assign fn[g]  = func_r[g*8 +: 8];
      assign act[g] = term_i[g] ^ pol_r[g];
    end
  endgenerate

  always_comb begin
    f_up = 1'b0; f_dn = 1'b0; f_forward_jog_input = 1'b0; f_reverse_jog_input = 1'b0; f_frst = 1'b0;
    f_fstop = 1'b0; f_m2 = 1'b0; f_pidc = 1'b0; f_acc1 = 1'b0; f_acc2 = 1'b0;
    f_lock = 1'b0; f_sh = 1'b0; has_lock = 1'b0; has_sh = 1'b0;
    has_up = 1'b0; has_dn = 1'b0; conflict = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      case (fn[i])
        `DIF_FN_UP:       begin f_up = f_up | act[i]; has_up = 1'b1; end
        `DIF_FN_DOWN:     begin f_dn = f_dn | act[i]; has_dn = 1'b1; end
        `DIF_FN_FORWARD_JOG_INPUT:     f_forward_jog_input = f_forward_jog_input | act[i];
        `DIF_FN_REVERSE_JOG_INPUT:     f_reverse_jog_input = f_reverse_jog_input | act[i];
        `DIF_FN_FRESET:   f_frst = f_frst | act[i];
        `DIF_FN_FSTOP_NO: f_fstop = f_fstop | act[i];
        `DIF_FN_FSTOP_NC: f_fstop = f_fstop | ~act[i];
        `DIF_FN_MOTOR2:   f_m2 = f_m2 | act[i];
        `DIF_FN_PIDCAN:   f_pidc = f_pidc | act[i];
        `DIF_FN_ACC1:     f_acc1 = f_acc1 | act[i];
        `DIF_FN_ACC2:     f_acc2 = f_acc2 | act[i];
        `DIF_FN_LOCK:     begin f_lock = f_lock | act[i]; has_lock = 1'b1; end
        `DIF_FN_SH:       begin f_sh = f_sh | act[i]; has_sh = 1'b1; end
        default:          ;
      endcase
      if (fn[i] == `DIF_FN_RHOLD || fn[i] == `DIF_FN_AUP || fn[i] == `DIF_FN_ADN ||
          (fn[i] >= `DIF_FN_OFS0 && fn[i] <= `DIF_FN_OFS2))
        conflict = 1'b1;
    end
    conflict = (has_sh && (conflict || has_up || has_dn)) || (has_up != has_dn);
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic bus_req, wr_ok, locked;
  logic [7:0] adr;
  logic [31:0] wmask;
  assign adr     = wb_adr_i[7:0];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign locked  = has_lock && !f_lock;
  assign wr_ok   = bus_req && wb_we_i && !locked;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  logic [31:0] tmp;
  always_comb begin
    ack_nxt = bus_req;
    ctrl_nxt = ctrl_r; func_nxt = func_r; pol_nxt = pol_r; uplim_nxt = uplim_r;
    lolim_nxt = lolim_r; jogref_nxt = jogref_r; step_nxt = step_r;
    rejected_nxt = rejected_r | (bus_req && wb_we_i && locked);
    rdat_nxt = rdat_r;
    tmp = 32'h0000_0000;
    if (wr_ok) begin
      case (adr)
        `DIF_REG_CTRL:   ctrl_nxt = merge(ctrl_r, wmask, wb_dat_i);
        `DIF_REG_FUNC:   func_nxt[31:0] = merge(func_r[31:0], wmask, wb_dat_i);
        `DIF_REG_POL:    begin tmp = merge({24'h0, pol_r}, wmask, wb_dat_i); pol_nxt = tmp[7:0]; end
        `DIF_REG_UPLIM:  begin tmp = merge({16'h0, uplim_r}, wmask, wb_dat_i); uplim_nxt = tmp[15:0]; end
        `DIF_REG_LOLIM:  begin tmp = merge({16'h0, lolim_r}, wmask, wb_dat_i); lolim_nxt = tmp[15:0]; end
        `DIF_REG_JOGREF: begin tmp = merge({16'h0, jogref_r}, wmask, wb_dat_i); jogref_nxt = tmp[15:0]; end
        `DIF_REG_STEP:   begin tmp = merge({16'h0, step_r}, wmask, wb_dat_i); step_nxt = tmp[15:0]; end
        `DIF_REG_CMD:    func_nxt[63:32] = merge(func_r[63:32], wmask, wb_dat_i);
        default:         ;
      endcase
    end
    if (bus_req && !wb_we_i) begin
      case (adr)
        `DIF_REG_CTRL:   rdat_nxt = ctrl_r;
        `DIF_REG_FUNC:   rdat_nxt = func_r[31:0];
        `DIF_REG_POL:    rdat_nxt = {24'h0, pol_r};
        `DIF_REG_UPLIM:  rdat_nxt = {16'h0, uplim_r};
        `DIF_REG_LOLIM:  rdat_nxt = {16'h0, lolim_r};
        `DIF_REG_JOGREF: rdat_nxt = {16'h0, jogref_r};
        `DIF_REG_STEP:   rdat_nxt = {16'h0, step_r};
        `DIF_REG_STATUS: rdat_nxt = {22'h0, rejected_r, conflict, alarm_r, motor2_r,
                                     fault_r, sh_valid_r, st_r, 2'b00};
        `DIF_REG_FREF:   rdat_nxt = {16'h0, fref_r};
        `DIF_REG_CMD:    rdat_nxt = func_r[63:32];
        default:         rdat_nxt = `DIF_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run sequencing
  logic run, jog_f, jog_r, jog_any, running, fault_req, rst_ok, stop_m2;
  logic [15:0] up_sum, dn_dif, lo_eff;
  logic [16:0] sum17;
  assign run     = run_fwd_i | run_rev_i;
  assign jog_f   = f_forward_jog_input;
  assign jog_r   = f_reverse_jog_input && !ctrl_r[`DIF_CTRL_REVPRO];
  assign running = (st_r == DIF_RUN_ON) || (st_r == DIF_RUN_FSTOP);
  assign rst_ok  = (f_frst || reset_key_i) && !run;
  assign fault_req = fault_event_i || (jog_cnt_r >= 32'(JOG_CYC));

  always_comb begin
    jog_cnt_nxt = (f_forward_jog_input && f_reverse_jog_input) ? jog_cnt_r + 32'h1 : 32'h0;
    if (jog_cnt_r >= 32'(JOG_CYC) && f_forward_jog_input && f_reverse_jog_input) jog_cnt_nxt = jog_cnt_r;
    fault_nxt = fault_r;
    st_nxt = st_r;
    case (st_r)
      DIF_RUN_IDLE:  if (run || jog_f || jog_r) st_nxt = DIF_RUN_ON;
      DIF_RUN_ON:    if (f_fstop) st_nxt = DIF_RUN_FSTOP;
                     else if (!run && !jog_f && !jog_r) st_nxt = DIF_RUN_IDLE;
      DIF_RUN_FSTOP: if (motor_stopped_i && !f_fstop && !run) st_nxt = DIF_RUN_IDLE;
      DIF_RUN_FAULT: if (rst_ok) st_nxt = DIF_RUN_IDLE;
      default:       st_nxt = DIF_RUN_IDLE;
    endcase
    if (fault_req) begin
      st_nxt = DIF_RUN_FAULT;
      fault_nxt = 1'b1;
    end else if (st_r == DIF_RUN_FAULT && rst_ok) fault_nxt = 1'b0;
    stop_m2 = running && (f_m2 != motor2_r);
    motor2_nxt = running ? motor2_r : f_m2;
    alarm_nxt = stop_m2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference path
  always_comb begin
    sum17  = {1'b0, ud_ref_r} + {1'b0, step_r};
    up_sum = (sum17[16] || sum17[15:0] > uplim_r) ? uplim_r : sum17[15:0];
    dn_dif = (ud_ref_r > step_r) ? ud_ref_r - step_r : 16'h0000;
    ud_ref_nxt = ud_ref_r;
    stored_reached_nxt = stored_reached_r;
    if (!run) begin
      stored_reached_nxt = 1'b0;
      if (!ctrl_r[`DIF_CTRL_HOLD]) ud_ref_nxt = 16'h0000;
      else if (f_up || f_dn) ud_ref_nxt = 16'h0000;
      // hold on keeps ud_ref_r over a run cycle
    end else begin
      if (f_up && !f_dn) ud_ref_nxt = up_sum;
      else if (f_dn && !f_up) ud_ref_nxt = dn_dif;
      if (out_freq_i >= lolim_r) stored_reached_nxt = 1'b1;
    end
    if (ud_ref_nxt > uplim_r) ud_ref_nxt = uplim_r;
    case (ctrl_r[`DIF_CTRL_LIMSRC +: 2])
      2'd0:    lo_eff = lolim_r;
      2'd1:    lo_eff = (f_up || f_dn) ? analog_lim_i : 16'h0000;
      default: lo_eff = (stored_reached_r && (f_up || f_dn) && analog_lim_i > lolim_r)
                        ? analog_lim_i : lolim_r;
    endcase
    sh_cnt_nxt = f_sh ? ((sh_cnt_r >= 32'(SH_CYC)) ? sh_cnt_r : sh_cnt_r + 32'h1) : 32'h0;
    sh_ref_nxt = sh_ref_r;
    sh_valid_nxt = sh_valid_r;
    sh_done_nxt = f_sh && sh_done_r;
    if (sh_cnt_r >= 32'(SH_CYC) && !sh_done_r) begin
      sh_ref_nxt = analog_ref_i;
      sh_valid_nxt = 1'b1;
      sh_done_nxt = 1'b1;
    end
    if (jog_f || jog_r) fref_nxt = jogref_r;
    else if (has_sh) fref_nxt = sh_ref_r;
    else if (has_up) begin
      if (run && ctrl_r[`DIF_CTRL_LIMSRC +: 2] == 2'd1 && !(f_up || f_dn) && ud_ref_r == 16'h0)
        fref_nxt = 16'h0000;
      else
        fref_nxt = (ud_ref_r < lo_eff && run) ? lo_eff : ud_ref_r;
    end else fref_nxt = 16'h0000;
    if (fref_nxt > uplim_r && !(jog_f || jog_r)) fref_nxt = uplim_r;
  end

  always_comb begin
    drv_nxt.jog        = jog_f || jog_r;
    drv_nxt.fwd        = (st_nxt == DIF_RUN_ON) && (jog_f || (!jog_r && run_fwd_i));
    drv_nxt.rev        = (st_nxt == DIF_RUN_ON) && !jog_f && (jog_r || (!jog_f && run_rev_i));
    drv_nxt.coast      = (st_nxt == DIF_RUN_FAULT);
    drv_nxt.fast_decel = (st_nxt == DIF_RUN_FSTOP);
    drv_nxt.motor2     = motor2_nxt;
    drv_nxt.pid_active = ctrl_r[`DIF_CTRL_PIDEN] && !f_pidc;
    drv_nxt.ramp_set   = {f_acc2, f_acc1};
    drv_nxt.lockout    = locked;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r           <= `DIF_CTRL_RESET;
      func_r           <= 64'h0;
      pol_r            <= 8'h00;
      uplim_r          <= `DIF_UPLIM_RESET;
      lolim_r          <= 16'h0000;
      jogref_r         <= 16'h0000;
      step_r           <= `DIF_STEP_RESET;
      ack_r            <= 1'b0;
      rdat_r           <= 32'h0000_0000;
      ud_ref_r         <= 16'h0000;
      sh_ref_r         <= 16'h0000;
      sh_valid_r       <= 1'b0;
      sh_done_r        <= 1'b0;
      jog_cnt_r        <= 32'h0;
      sh_cnt_r         <= 32'h0;
      motor2_r         <= 1'b0;
      alarm_r          <= 1'b0;
      fault_r          <= 1'b0;
      stored_reached_r <= 1'b0;
      rejected_r       <= 1'b0;
      st_r             <= DIF_RUN_IDLE;
      fref_r           <= 16'h0000;
      drv_r            <= '0;
    end else begin
      ctrl_r           <= ctrl_nxt;
      func_r           <= func_nxt;
      pol_r            <= pol_nxt;
      uplim_r          <= uplim_nxt;
      lolim_r          <= lolim_nxt;
      jogref_r         <= jogref_nxt;
      step_r           <= step_nxt;
      ack_r            <= ack_nxt;
      rdat_r           <= rdat_nxt;
      ud_ref_r         <= ud_ref_nxt;
      sh_ref_r         <= sh_ref_nxt;
      sh_valid_r       <= sh_valid_nxt;
      sh_done_r        <= sh_done_nxt;
      jog_cnt_r        <= jog_cnt_nxt;
      sh_cnt_r         <= sh_cnt_nxt;
      motor2_r         <= motor2_nxt;
      alarm_r          <= alarm_nxt;
      fault_r          <= fault_nxt;
      stored_reached_r <= stored_reached_nxt;
      rejected_r       <= rejected_nxt;
      st_r             <= st_nxt;
      fref_r           <= fref_nxt;
      drv_r            <= drv_nxt;
    end
  end

  assign wb_ack_o               = ack_r;
  assign wb_dat_o               = rdat_r;
  assign freq_ref_o             = fref_r;
  assign drive_o                = drv_r;
  assign fault_contact_o        = fault_r;
  assign motor2_out_o           = motor2_r;
  assign run_alarm_o            = alarm_r;
  assign input_conflict_error_o = conflict;

endmodule

// File: test/dif_input_logic_properties.sv
// concurrent checks on the drive input function logic, bound to its top module
// assumes dif_defs.svh on the include path and a synchronous active-high reset
`include "dif_defs.svh"
module dif_props
  import dif_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        run_fwd_i,
  input wire logic        run_rev_i,
  input wire logic [15:0] freq_ref_o,
  input wire dif_drive_t  drive_o,
  input wire logic        fault_contact_o,
  input wire logic        motor2_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        wr;
  logic        run;
  logic [4:0]  ctrl_r;
  logic [4:0]  ctrl_nxt;
  logic [15:0] uplim_r;
  logic [15:0] uplim_nxt;
  //////////////////////////////////////////////////////////////////////////////
  // shadow of the control and upper limit registers
  assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign run = run_fwd_i || run_rev_i;
  always_comb begin
    ctrl_nxt  = ctrl_r;
    uplim_nxt = uplim_r;
    if (wr && wb_adr_i[7:0] == `DIF_REG_CTRL) ctrl_nxt = wb_dat_i[4:0];
    if (wr && wb_adr_i[7:0] == `DIF_REG_UPLIM) uplim_nxt = wb_dat_i[15:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r  <= 5'h00;
      uplim_r <= `DIF_UPLIM_RESET;
    end else begin
      ctrl_r  <= ctrl_nxt;
      uplim_r <= uplim_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_bus_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack not a single pulse");
  property p_reset_zero; $fell(rst_i) |-> freq_ref_o == 16'h0000 && !fault_contact_o; endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reference not zero");
  property p_uplim; !drive_o.jog |-> freq_ref_o <= uplim_r; endproperty
  a_uplim: assert property (p_uplim) else $error("reference above limit");
  property p_rev_prohibit; ctrl_r[`DIF_CTRL_REVPRO] |-> !(drive_o.jog && drive_o.rev); endproperty
  a_rev_prohibit: assert property (p_rev_prohibit) else $error("reverse jog ran");
  property p_hold_clear;
    $past(run) && !run && !ctrl_r[0] && !drive_o.jog && !fault_contact_o
      |-> ##[1:2] freq_ref_o == 16'h0000;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("reference kept");
  property p_fault_coast; fault_contact_o |-> drive_o.coast; endproperty
  a_fault_coast: assert property (p_fault_coast) else $error("fault without coast");
  property p_reset_ignored; fault_contact_o && run |=> fault_contact_o; endproperty
  a_reset_ignored: assert property (p_reset_ignored) else $error("fault cleared in run");
  property p_motor2_out; motor2_out_o == drive_o.motor2; endproperty
  a_motor2_out: assert property (p_motor2_out) else $error("motor2 output differs");
  property p_motor_frozen; run [*3] |=> $stable(drive_o.motor2); endproperty
  a_motor_frozen: assert property (p_motor_frozen) else $error("motor changed in run");
endmodule
bind dif_input_logic dif_props u_props (
  .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .run_fwd_i, .run_rev_i, .freq_ref_o, .drive_o, .fault_contact_o, .motor2_out_o
);

// File: test/dif_switch_model.sv
// contact model for the input terminals: switches wired n.o. or n.c.
// assumes the bench sets contact states just after a clock edge
module dif_switch_model #(
  parameter int N = 5
) (
  input  wire logic [N-1:0] close_i,
  input  wire logic [N-1:0] nc_i,
  output      logic [N-1:0] term_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // an n.c. contact shows a high level while released
  assign term_o = close_i ^ nc_i;
endmodule

// File: test/tb.sv
// self-checking bench for the drive input function logic
// assumes dif_defs.svh on the include path; shortened jog and hold counts
`include "dif_defs.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb
  import dif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic we; logic [31:0] d; logic [31:0] e;} dif_row_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [4:0]  term_i, cl = 5'h00, nc = 5'h00;
  logic        run_fwd_i = 1'b0, run_rev_i = 1'b0, reset_key_i = 1'b0;
  logic        motor_stopped_i = 1'b0, fault_event_i = 1'b0, wb_ack_o;
  logic [15:0] analog_ref_i = 16'h0, analog_lim_i = 16'h0, out_freq_i = 16'h0, freq_ref_o;
  dif_drive_t  drive_o;
  logic        fault_contact_o, motor2_out_o, run_alarm_o, input_conflict_error_o;
  int          errors = 0, check_count = 0;
  dif_row_t    rows [7] = '{
    '{`DIF_REG_CTRL, 1'b0, 32'h0, `DIF_CTRL_RESET},
    '{`DIF_REG_UPLIM, 1'b0, 32'h0, {16'h0, `DIF_UPLIM_RESET}},
    '{`DIF_REG_STEP, 1'b0, 32'h0, {16'h0, `DIF_STEP_RESET}},
    '{8'hFC, 1'b1, 32'hFFFF, 32'h0},
    '{8'hFC, 1'b0, 32'h0, `DIF_UNMAPPED},
    '{`DIF_REG_JOGREF, 1'b1, 32'h30, 32'h0},
    '{`DIF_REG_JOGREF, 1'b0, 32'h0, 32'h30}};
  //////////////////////////////////////////////////////////////////////////////
  dif_input_logic #(.NUM_TERM(5), .JOG_CYC(20), .SH_CYC(10)) DUT (
    .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .term_i, .run_fwd_i, .run_rev_i, .reset_key_i, .motor_stopped_i,
    .fault_event_i, .analog_ref_i, .analog_lim_i, .out_freq_i, .freq_ref_o, .drive_o,
    .fault_contact_o, .motor2_out_o, .run_alarm_o, .input_conflict_error_o);
  dif_switch_model #(.N(5)) u_sw (.close_i(cl), .nc_i(nc), .term_o(term_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    wb_we_i  <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      tally_and_finish;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(a, d, 1'b1, x);
  endtask
  task automatic press(input logic [4:0] m, input int n);
    cl <= m;
    tk(n);
    cl <= 5'h00;
    tk(3);
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    tk(5000);
    errors++;
    tally_and_finish;
  end
  initial begin
    tk(10);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].a, rows[i].d, rows[i].we, q);
      if (!rows[i].we) `CHK("reg", rows[i].e, q)
    end
    // up/down stepping, limits and hold
    w(`DIF_REG_FUNC, 32'h1312_1110);
    w(`DIF_REG_CMD, 32'h0000_0016);
    w(`DIF_REG_STEP, 32'h5);
    w(`DIF_REG_UPLIM, 32'h64);
    run_fwd_i <= 1'b1;
    tk(3);
    press(5'h01, 4);
    `CHK("up", 16'h0014, freq_ref_o)
    press(5'h03, 3);
    `CHK("both", 16'h0014, freq_ref_o)
    press(5'h02, 2);
    `CHK("down", 16'h000A, freq_ref_o)
    press(5'h01, 30);
    `CHK("uplim", 16'h0064, freq_ref_o)
    run_fwd_i <= 1'b0;
    tk(3);
    `CHK("clear", 16'h0000, freq_ref_o)
    w(`DIF_REG_LOLIM, 32'h20);
    run_fwd_i <= 1'b1;
    tk(3);
    `CHK("lolim", 16'h0020, freq_ref_o)
    run_fwd_i <= 1'b0;
    w(`DIF_REG_LOLIM, 32'h0);
    w(`DIF_REG_CTRL, 32'h1);
    run_fwd_i <= 1'b1;
    tk(3);
    press(5'h01, 2);
    run_fwd_i <= 1'b0;
    tk(3);
    `CHK("held", 16'h000A, freq_ref_o)
    run_fwd_i <= 1'b1;
    tk(3);
    `CHK("restart", 16'h000A, freq_ref_o)
    run_fwd_i <= 1'b0;
    press(5'h01, 1);
    `CHK("wipe", 16'h0000, freq_ref_o)
    // jog, reverse prohibit, jog conflict fault and its reset
    w(`DIF_REG_CTRL, 32'h0);
    cl <= 5'h04;
    tk(3);
    `CHK("jog", 1'b1, drive_o.jog && drive_o.fwd)
    `CHK("jogref", 16'h0030, freq_ref_o)
    cl <= 5'h00;
    w(`DIF_REG_CTRL, 32'h2);
    press(5'h08, 3);
    `CHK("revpro", 1'b0, drive_o.rev)
    w(`DIF_REG_CTRL, 32'h0);
    cl <= 5'h08;
    tk(3);
    `CHK("reverse_jog_input", 1'b1, drive_o.rev)
    cl <= 5'h0C;
    tk(15);
    `CHK("early", 1'b0, fault_contact_o)
    tk(10);
    `CHK("fault", 1'b1, fault_contact_o && drive_o.coast)
    cl <= 5'h00;
    run_rev_i <= 1'b1;
    reset_key_i <= 1'b1;
    tk(3);
    `CHK("ignored", 1'b1, fault_contact_o)
    run_rev_i <= 1'b0;
    reset_key_i <= 1'b0;
    tk(2);
    reset_key_i <= 1'b1;
    tk(3);
    `CHK("cleared", 1'b0, fault_contact_o)
    reset_key_i <= 1'b0;
    // motor 2 select, frozen in run
    cl <= 5'h10;
    tk(3);
    `CHK("m2", 1'b1, motor2_out_o && drive_o.motor2)
    run_fwd_i <= 1'b1;
    tk(3);
    cl <= 5'h00;
    tk(2);
    `CHK("frozen", 1'b1, drive_o.motor2 && run_alarm_o)
    run_fwd_i <= 1'b0;
    tk(3);
    `CHK("m1", 1'b0, drive_o.motor2)
    // fast-stop and restart lock
    w(`DIF_REG_CMD, 32'h15);
    run_rev_i <= 1'b1;
    tk(3);
    cl <= 5'h10;
    tk(3);
    `CHK("fdecel", 1'b1, drive_o.fast_decel)
    cl <= 5'h00;
    motor_stopped_i <= 1'b1;
    tk(3);
    wb(`DIF_REG_STATUS, 32'h0, 1'b0, q);
    `CHK("fstate", 2'h2, q[3:2])
    run_rev_i <= 1'b0;
    tk(3);
    run_rev_i <= 1'b1;
    tk(3);
    wb(`DIF_REG_STATUS, 32'h0, 1'b0, q);
    `CHK("rerun", 2'h1, q[3:2])
    run_rev_i <= 1'b0;
    // program lockout
    w(`DIF_REG_CMD, 32'h1B);
    tk(2);
    `CHK("lock", 1'b1, drive_o.lockout)
    w(`DIF_REG_STEP, 32'h7);
    wb(`DIF_REG_STEP, 32'h0, 1'b0, q);
    `CHK("locked", 32'h5, q)
    wb(`DIF_REG_STATUS, 32'h0, 1'b0, q);
    `CHK("reject", 1'b1, q[9])
    cl <= 5'h10;
    tk(3);
    w(`DIF_REG_STEP, 32'h7);
    wb(`DIF_REG_STEP, 32'h0, 1'b0, q);
    `CHK("open", 32'h7, q)
    w(`DIF_REG_CMD, 32'h1E);
    cl <= 5'h00;
    // ramp selects, sample/hold, conflict, pid cancel, reset with run off
    w(`DIF_REG_FUNC, 32'h1312_1A07);
    `CHK("noconf", 1'b0, input_conflict_error_o)
    press(5'h03, 3);
    press(5'h02, 3);
    cl <= 5'h03;
    tk(3);
    `CHK("ramp3", 2'b11, drive_o.ramp_set)
    cl <= 5'h02;
    tk(3);
    `CHK("ramp2", 2'b10, drive_o.ramp_set)
    analog_ref_i <= 16'h0042;
    cl <= 5'h10;
    tk(5);
    `CHK("shwait", 16'h0000, freq_ref_o)
    tk(10);
    `CHK("sample", 16'h0042, freq_ref_o)
    cl <= 5'h00;
    w(`DIF_REG_FUNC, 32'h1312_1A0A);
    tk(1);
    `CHK("conf", 1'b1, input_conflict_error_o)
    w(`DIF_REG_CTRL, 32'h10);
    w(`DIF_REG_FUNC, 32'h1312_190A);
    tk(2);
    `CHK("pid", 1'b1, drive_o.pid_active)
    cl <= 5'h02;
    tk(3);
    `CHK("pidcan", 1'b0, drive_o.pid_active)
    cl <= 5'h00;
    rst_i <= 1'b1;
    tk(2);
    rst_i <= 1'b0;
    tk(2);
    `CHK("zero", 16'h0000, freq_ref_o)
    tally_and_finish;
  end
endmodule
